// ===== hdl/trap_vector_pkg.sv
package trap_vector_pkg;

	// placement of the entry tables
	typedef enum logic [2:0] {
		PLACE_AREA_TOP = 3'h4,
		PLACE_AREA_0   = 3'h0,
		PLACE_AREA_1   = 3'h1,
		PLACE_AREA_2   = 3'h2,
		PLACE_ONCHIP   = 3'h3
	} placement_e;

	localparam logic [31:0] TOP_TRAP_BASE  = 32'hffff_ff00;
	localparam logic [31:0] TOP_SOFT_BASE  = 32'hffff_fe00;
	localparam logic [31:0] LOW_SOFT_BASE  = 32'h0000_01fc;
	localparam logic [31:0] LOW_TRAP_LAST  = 32'h0000_00fc;
	localparam logic [3:0]  DIGIT_AREA_0   = 4'h0;
	localparam logic [3:0]  DIGIT_AREA_1   = 4'h4;
	localparam logic [3:0]  DIGIT_AREA_2   = 4'h8;
	localparam logic [3:0]  DIGIT_ONCHIP   = 4'hc;
	localparam int          TRAP_STRIDE_SH = 2;
	localparam int          SOFT_STRIDE_SH = 4;

	localparam logic [5:0]  TRAP_ALL_ONES  = 6'h3f;
	localparam logic [5:0]  TRAP_RESERVED  = 6'h38;
	localparam logic [5:0]  TRAP_TRACE     = 6'h39;
	localparam logic [5:0]  TRAP_PARITY    = 6'h3a;
	localparam logic [5:0]  TRAP_EXT_OVF   = 6'h3b;
	localparam logic [5:0]  TRAP_RANGE     = 6'h3c;
	localparam logic [5:0]  TRAP_TIMER     = 6'h37;
	localparam logic [5:0]  TRAP_GP3       = 6'h36;
	localparam logic [5:0]  TRAP_EXT1      = 6'h35;
	localparam logic [5:0]  TRAP_EXT2      = 6'h34;
	localparam logic [5:0]  TRAP_EXT3      = 6'h33;
	localparam logic [5:0]  TRAP_EXT4      = 6'h32;
	localparam logic [5:0]  TRAP_GP1       = 6'h31;
	localparam logic [5:0]  TRAP_GP2       = 6'h30;

	localparam logic [4:0]  PRIO_RANGE     = 5'h02;
	localparam logic [4:0]  PRIO_EXT_OVF   = 5'h03;
	localparam logic [4:0]  PRIO_PARITY    = 5'h04;
	localparam logic [4:0]  PRIO_GP3       = 5'h05;
	localparam logic [4:0]  PRIO_EXT1      = 5'h07;
	localparam logic [4:0]  PRIO_EXT2      = 5'h09;
	localparam logic [4:0]  PRIO_EXT3      = 5'h0b;
	localparam logic [4:0]  PRIO_EXT4      = 5'h0d;
	localparam logic [4:0]  PRIO_GP1       = 5'h0e;
	localparam logic [4:0]  PRIO_GP2       = 5'h0f;
	localparam logic [4:0]  PRIO_TRACE     = 5'h10;
	localparam logic [4:0]  PRIO_RESERVED  = 5'h11;
	localparam logic [4:0]  PRIO_TIMER_LO  = 5'h06;
	localparam logic [4:0]  PRIO_NONE      = 5'h1f;

	// source index into the pending vector
	localparam int SRC_RANGE    = 0;
	localparam int SRC_EXT_OVF  = 1;
	localparam int SRC_PARITY   = 2;
	localparam int SRC_GP3      = 3;
	localparam int SRC_TIMER    = 4;
	localparam int SRC_EXT1     = 5;
	localparam int SRC_EXT2     = 6;
	localparam int SRC_EXT3     = 7;
	localparam int SRC_EXT4     = 8;
	localparam int SRC_GP1      = 9;
	localparam int SRC_GP2      = 10;
	localparam int SRC_TRACE    = 11;
	localparam int SRC_RESERVED = 12;
	localparam int SRC_COUNT    = 13;

	// software op index 0 = single add ... 13 = narrow convert, 14 reserved, 15 generic
	localparam logic [3:0]  SOFT_RESERVED  = 4'he;
	localparam logic [3:0]  SOFT_GENERIC   = 4'hf;

	localparam logic [3:0]  SOFT_BASE_CYC  = 4'h6;
	localparam logic [3:0]  SOFT_LAT_FREE  = 4'h4;
	localparam logic [3:0]  CALL_BASE_CYC  = 4'h2;
	localparam logic [3:0]  ONE_CYC        = 4'h1;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_DONE = 2'b11
	} state_e;

	typedef struct packed {
		logic [2:0] kind;   // 0 none,1 plain,2 call,3 trap,4 soft,5 all-ones
		logic       taken;
		logic [5:0] trap_num;
		logic [3:0] soft_op;
		logic [3:0] mem_lat;
	} instr_req_s;

	typedef struct packed {
		logic        valid;
		logic [31:0] addr;
		logic [5:0]  trap_num;
		logic [4:0]  prio;
	} vector_s;

endpackage : trap_vector_pkg

// ===== hdl/trap_vector_dispatch.sv
// What this block does
// - low placement puts 0, 4, 8 or C in the top address digit
// - low placement: trap entries 4 bytes apart, trap 63 first, trap 0 at FC
// - an all-ones instruction code vectors to trap 63
// - range/pointer/frame/privilege 2, extended overflow 3, parity 4
// - gp pin 3 at 5, ext lines 7/9/11/13, gp pins 1 and 2 at 14/15
// - trace at 16, reserved trap 56 at 17, the lowest
// - timer through trap 55 takes priority 6, 8, 10 or 12 by setting
// - top placement: software entries from FFFF FE00, opcode order, 16 bytes apart
// - top placement: FFFF FEE0 unused, generic op at FFFF FEF0
// - low placement: software entries reversed, generic at 010C up to add at 01FC
// - software dispatch takes 6 cycles plus read latency above 4
// - call or trap not taken 1 cycle, taken 2 plus read latency
// - counts are processor cycles, the all-ones code takes 2 plus read latency, other instructions take one cycle
// - after reset the tables sit at the end of the top area
// - top placement: trap entries ascending 4 bytes apart from FFFF FF00
// - conditional traps use the entry of the plain trap with that number
module trap_vector_dispatch (
	input  wire logic                             sys_clk_i,
	input  wire logic                             sys_rst_i,
	input  wire logic [2:0]                       placement_i,
	input  wire logic                             placement_load_i,
	input  wire logic [1:0]                       timer_prio_sel_i,
	input  wire logic [trap_vector_pkg::SRC_COUNT-1:0] event_i,
	input  wire trap_vector_pkg::instr_req_s      instr_i,
	input  wire logic                             instr_valid_i,
	output logic                                  instr_ready_o,
	output logic                                  instr_done_o,
	output logic                                  event_taken_o,
	output trap_vector_pkg::vector_s              vector_o,
	output logic [trap_vector_pkg::SRC_COUNT-1:0] pending_o,
	output logic [2:0]                            placement_o
);

	typedef struct packed {
		trap_vector_pkg::state_e     state;
		logic [2:0]                  place;
		logic [1:0]                  tsel;
		logic [trap_vector_pkg::SRC_COUNT-1:0] pend;
		logic [4:0]                  cnt;
		logic                        done;
		logic                        ev_taken;
		logic                        rdy;
		trap_vector_pkg::vector_s    vec;
	} state_s;

	state_s s_q;
	state_s s_d;

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [3:0] area_digit(input logic [2:0] p);
		unique case (p)
			3'h1:    area_digit = trap_vector_pkg::DIGIT_AREA_1;
			3'h2:    area_digit = trap_vector_pkg::DIGIT_AREA_2;
			3'h3:    area_digit = trap_vector_pkg::DIGIT_ONCHIP;
			default: area_digit = trap_vector_pkg::DIGIT_AREA_0;
		endcase
	endfunction : area_digit

	function automatic logic [31:0] trap_addr(input logic [2:0] p, input logic [5:0] n);
		logic [31:0] off;
		off = {24'h00_0000, n, 2'b00};
		if (p == trap_vector_pkg::PLACE_AREA_TOP) begin
			trap_addr = trap_vector_pkg::TOP_TRAP_BASE | off;
		end else begin
			trap_addr = {area_digit(p),
				28'(trap_vector_pkg::LOW_TRAP_LAST - off)};
		end
	endfunction : trap_addr

	function automatic logic [31:0] soft_addr(input logic [2:0] p, input logic [3:0] op);
		logic [31:0] off;
		off = {24'h00_0000, op, 4'h0};
		if (p == trap_vector_pkg::PLACE_AREA_TOP) begin
			soft_addr = trap_vector_pkg::TOP_SOFT_BASE | off;
		end else begin
			soft_addr = {area_digit(p),
				28'(trap_vector_pkg::LOW_SOFT_BASE - off)};
		end
	endfunction : soft_addr

	////////////////////////////////////////////////////////////////////////////////
	logic [4:0] prio_tab [trap_vector_pkg::SRC_COUNT];
	logic [5:0] trap_tab [trap_vector_pkg::SRC_COUNT];
	logic [4:0] timer_prio;

	always_comb begin
		timer_prio = 5'(trap_vector_pkg::PRIO_TIMER_LO + {2'b00, s_q.tsel, 1'b0});
		prio_tab[trap_vector_pkg::SRC_RANGE]    = trap_vector_pkg::PRIO_RANGE;
		prio_tab[trap_vector_pkg::SRC_EXT_OVF]  = trap_vector_pkg::PRIO_EXT_OVF;
		prio_tab[trap_vector_pkg::SRC_PARITY]   = trap_vector_pkg::PRIO_PARITY;
		prio_tab[trap_vector_pkg::SRC_GP3]      = trap_vector_pkg::PRIO_GP3;
		prio_tab[trap_vector_pkg::SRC_TIMER]    = timer_prio;
		prio_tab[trap_vector_pkg::SRC_EXT1]     = trap_vector_pkg::PRIO_EXT1;
		prio_tab[trap_vector_pkg::SRC_EXT2]     = trap_vector_pkg::PRIO_EXT2;
		prio_tab[trap_vector_pkg::SRC_EXT3]     = trap_vector_pkg::PRIO_EXT3;
		prio_tab[trap_vector_pkg::SRC_EXT4]     = trap_vector_pkg::PRIO_EXT4;
		prio_tab[trap_vector_pkg::SRC_GP1]      = trap_vector_pkg::PRIO_GP1;
		prio_tab[trap_vector_pkg::SRC_GP2]      = trap_vector_pkg::PRIO_GP2;
		prio_tab[trap_vector_pkg::SRC_TRACE]    = trap_vector_pkg::PRIO_TRACE;
		prio_tab[trap_vector_pkg::SRC_RESERVED] = trap_vector_pkg::PRIO_RESERVED;
		trap_tab[trap_vector_pkg::SRC_RANGE]    = trap_vector_pkg::TRAP_RANGE;
		trap_tab[trap_vector_pkg::SRC_EXT_OVF]  = trap_vector_pkg::TRAP_EXT_OVF;
		trap_tab[trap_vector_pkg::SRC_PARITY]   = trap_vector_pkg::TRAP_PARITY;
		trap_tab[trap_vector_pkg::SRC_GP3]      = trap_vector_pkg::TRAP_GP3;
		trap_tab[trap_vector_pkg::SRC_TIMER]    = trap_vector_pkg::TRAP_TIMER;
		trap_tab[trap_vector_pkg::SRC_EXT1]     = trap_vector_pkg::TRAP_EXT1;
		trap_tab[trap_vector_pkg::SRC_EXT2]     = trap_vector_pkg::TRAP_EXT2;
		trap_tab[trap_vector_pkg::SRC_EXT3]     = trap_vector_pkg::TRAP_EXT3;
		trap_tab[trap_vector_pkg::SRC_EXT4]     = trap_vector_pkg::TRAP_EXT4;
		trap_tab[trap_vector_pkg::SRC_GP1]      = trap_vector_pkg::TRAP_GP1;
		trap_tab[trap_vector_pkg::SRC_GP2]      = trap_vector_pkg::TRAP_GP2;
		trap_tab[trap_vector_pkg::SRC_TRACE]    = trap_vector_pkg::TRAP_TRACE;
		trap_tab[trap_vector_pkg::SRC_RESERVED] = trap_vector_pkg::TRAP_RESERVED;
	end

	// lowest priority value among pending sources
	logic [4:0] best_prio;
	logic [3:0] best_idx;
	logic       any_pend;
	logic [trap_vector_pkg::SRC_COUNT-1:0] pend_now;

	always_comb begin
		pend_now  = s_q.pend | event_i;
		best_prio = trap_vector_pkg::PRIO_NONE;
		best_idx  = 4'h0;
		any_pend  = 1'b0;
		for (int i = 0; i < trap_vector_pkg::SRC_COUNT; i++) begin
			if (pend_now[i] && (prio_tab[i] < best_prio)) begin
				best_prio = prio_tab[i];
				best_idx  = 4'(i);
				any_pend  = 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	logic [4:0] lat_extra;
	logic [4:0] cycles;

	always_comb begin
		lat_extra = 5'h00;
		cycles    = {1'b0, trap_vector_pkg::ONE_CYC};
		unique case (instr_i.kind)
			3'h2, 3'h3: begin
				if (instr_i.taken) begin
					cycles = 5'(trap_vector_pkg::CALL_BASE_CYC + instr_i.mem_lat);
				end
			end
			3'h4: begin
				if (instr_i.mem_lat > trap_vector_pkg::SOFT_LAT_FREE) begin
					lat_extra = 5'(instr_i.mem_lat - trap_vector_pkg::SOFT_LAT_FREE);
				end
				cycles = 5'(trap_vector_pkg::SOFT_BASE_CYC + lat_extra);
			end
			3'h5: begin
				cycles = 5'(trap_vector_pkg::CALL_BASE_CYC + instr_i.mem_lat);
			end
			default: begin
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		s_d          = s_q;
		s_d.done     = 1'b0;
		s_d.ev_taken = 1'b0;
		s_d.pend     = pend_now;
		if (placement_load_i && placement_i <= 3'h4) begin
			s_d.place = placement_i;
			s_d.tsel  = timer_prio_sel_i;
		end
		unique case (s_q.state)
			trap_vector_pkg::ST_IDLE: begin
				if (any_pend) begin
					// events win over a new instruction; the rest stay pending
					s_d.pend[best_idx] = 1'b0;
					s_d.ev_taken       = 1'b1;
					s_d.vec.valid      = 1'b1;
					s_d.vec.trap_num   = trap_tab[best_idx];
					s_d.vec.prio       = best_prio;
					s_d.vec.addr       = trap_addr(s_q.place, trap_tab[best_idx]);
				end else if (instr_valid_i && s_q.rdy) begin
					s_d.vec.valid    = 1'b0;
					s_d.vec.prio     = trap_vector_pkg::PRIO_NONE;
					s_d.vec.trap_num = 6'h00;
					s_d.vec.addr     = 32'h0000_0000;
					if (instr_i.kind == 3'h3) begin
						s_d.vec.valid    = instr_i.taken;
						s_d.vec.trap_num = instr_i.trap_num;
						s_d.vec.addr     = trap_addr(s_q.place, instr_i.trap_num);
					end else if (instr_i.kind == 3'h5) begin
						s_d.vec.valid    = 1'b1;
						s_d.vec.trap_num = trap_vector_pkg::TRAP_ALL_ONES;
						s_d.vec.addr     = trap_addr(s_q.place,
							trap_vector_pkg::TRAP_ALL_ONES);
					end else if (instr_i.kind == 3'h4) begin
						s_d.vec.valid = 1'b1;
						s_d.vec.addr  = soft_addr(s_q.place, instr_i.soft_op);
					end
					if (cycles == 5'h01) begin
						s_d.done = 1'b1;
					end else begin
						s_d.cnt   = 5'(cycles - 5'h02);
						s_d.state = trap_vector_pkg::ST_WAIT;
					end
				end
			end
			trap_vector_pkg::ST_WAIT: begin
				if (s_q.cnt == 5'h00) begin
					s_d.done  = 1'b1;
					s_d.state = trap_vector_pkg::ST_DONE;
				end else begin
					s_d.cnt = 5'(s_q.cnt - 5'h01);
				end
			end
			trap_vector_pkg::ST_DONE: begin
				s_d.state = trap_vector_pkg::ST_IDLE;
			end
			default: begin
				s_d.state = trap_vector_pkg::ST_IDLE;
			end
		endcase
		// ready is registered so the port comes straight from a flip-flop
		s_d.rdy = (s_d.state == trap_vector_pkg::ST_IDLE) && !s_d.done;
	end

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			s_q       <= '0;
			s_q.state <= trap_vector_pkg::ST_IDLE;
			s_q.place <= trap_vector_pkg::PLACE_AREA_TOP;
			s_q.vec.prio <= trap_vector_pkg::PRIO_NONE;
			s_q.rdy   <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign instr_ready_o = s_q.rdy;
	assign instr_done_o  = s_q.done;
	assign event_taken_o = s_q.ev_taken;
	assign vector_o      = s_q.vec;
	assign pending_o     = s_q.pend;
	assign placement_o   = s_q.place;

endmodule : trap_vector_dispatch

// ===== sim/fetch_model.sv
module fetch_model (
	input  wire logic                        sys_clk_i,
	input  wire logic                        go_i,
	input  wire trap_vector_pkg::instr_req_s req_i,
	input  wire logic                        instr_ready_i,
	output trap_vector_pkg::instr_req_s      instr_o,
	output logic                             instr_valid_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		instr_o       = '0;
		instr_valid_o = 1'b0;
	end
	// hold the request until ready is seen at an edge; a released bus shows inverted data
	always @(posedge sys_clk_i) begin
		if (instr_valid_o && instr_ready_i) begin
			instr_valid_o <= #1 1'b0;
			instr_o       <= #1 ~instr_o;
		end else if (!instr_valid_o && go_i) begin
			instr_valid_o <= #1 1'b1;
			instr_o       <= #1 req_i;
		end
	end
endmodule : fetch_model

// ===== sim/trap_vector_dispatch_chk.sv
module trap_vector_dispatch_chk (
	input wire logic                                  sys_clk_i,
	input wire logic                                  sys_rst_i,
	input wire logic [2:0]                            placement_i,
	input wire logic                                  placement_load_i,
	input wire logic [1:0]                            timer_prio_sel_i,
	input wire logic [trap_vector_pkg::SRC_COUNT-1:0] event_i,
	input wire trap_vector_pkg::instr_req_s           instr_i,
	input wire logic                                  instr_valid_i,
	input wire logic                                  instr_ready_o,
	input wire logic                                  instr_done_o,
	input wire logic                                  event_taken_o,
	input wire trap_vector_pkg::vector_s              vector_o,
	input wire logic [trap_vector_pkg::SRC_COUNT-1:0] pending_o,
	input wire logic [2:0]                            placement_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);
	logic        take;
	logic [31:0] low_base;
	assign take     = instr_valid_i && instr_ready_o && pending_o == '0 && event_i == '0;
	assign low_base = {placement_o[1:0], 30'h0};

	reset_place_a: assert property (disable iff (1'b0)
		sys_rst_i |=> placement_o == 3'h4)
		else $error("placement not top after reset");
	place_load_a: assert property (
		placement_load_i && placement_i <= 3'h4 |=> placement_o == $past(placement_i))
		else $error("placement not loaded");
	plain_one_a: assert property (take && instr_i.kind == 3'd1 |=> instr_done_o)
		else $error("plain instruction not one cycle");
	call_skip_a: assert property (
		take && (instr_i.kind == 3'd2 || instr_i.kind == 3'd3) && !instr_i.taken
		|=> instr_done_o)
		else $error("untaken call or trap not one cycle");
	trap_taken_a: assert property (take && instr_i.kind == 3'd3 && instr_i.taken && instr_i.mem_lat == 4'h0
		|=> !instr_done_o ##1 instr_done_o)
		else $error("taken trap cost wrong");
	soft_cost_a: assert property (take && instr_i.kind == 3'd4 && instr_i.mem_lat <= 4'h4
		|=> !instr_done_o [*5] ##1 instr_done_o)
		else $error("software dispatch cost wrong");
	all_ones_a: assert property (take && instr_i.kind == 3'd5 |=> vector_o.trap_num == 6'h3f)
		else $error("all-ones code not trap 63");
	soft_top_a: assert property (take && instr_i.kind == 3'd4 && placement_o == 3'h4
		|=> vector_o.addr == 32'hffff_fe00 + {24'h0, $past(instr_i.soft_op), 4'h0})
		else $error("top software entry wrong");
	soft_low_a: assert property (take && instr_i.kind == 3'd4 && placement_o < 3'h4
		|=> vector_o.addr == $past(low_base) + 32'h0000_01fc
			- {24'h0, $past(instr_i.soft_op), 4'h0})
		else $error("low software entry wrong");
	trap_top_a: assert property (event_taken_o && placement_o == 3'h4
		|-> vector_o.addr == 32'hffff_ff00 + {24'h0, vector_o.trap_num, 2'b0})
		else $error("top trap entry wrong");
	trap_low_a: assert property (event_taken_o && placement_o < 3'h4
		|-> vector_o.addr == low_base + 32'h0000_00fc - {24'h0, vector_o.trap_num, 2'b0})
		else $error("low trap entry wrong");
endmodule : trap_vector_dispatch_chk

bind trap_vector_dispatch trap_vector_dispatch_chk u_trap_vector_dispatch_chk (.sys_clk_i, .sys_rst_i,
	.placement_i, .placement_load_i, .timer_prio_sel_i, .event_i, .instr_i, .instr_valid_i,
	.instr_ready_o, .instr_done_o, .event_taken_o, .vector_o, .pending_o, .placement_o);

// ===== sim/test_trap_vector_dispatch.sv
module test_trap_vector_dispatch;
	timeunit 1ns;
	timeprecision 1ps;
	logic                                  sys_clk_i, sys_rst_i, placement_load_i, instr_valid_i, go;
	logic                                  instr_ready_o, instr_done_o, event_taken_o;
	logic [2:0]                            placement_i, placement_o, place;
	logic [1:0]                            timer_prio_sel_i;
	logic [trap_vector_pkg::SRC_COUNT-1:0] event_i, pending_o;
	trap_vector_pkg::instr_req_s           instr_i, req;
	trap_vector_pkg::vector_s              vector_o;
	int                                    n_errors, samples_checked;
	logic [5:0]                            trap_of [13] = '{6'd60, 6'd59, 6'd58, 6'd54, 6'd55,
		6'd53, 6'd52, 6'd51, 6'd50, 6'd49, 6'd48, 6'd57, 6'd56};
	logic [4:0]                            prio_of [13] = '{5'd2, 5'd3, 5'd4, 5'd5, 5'd6, 5'd7,
		5'd9, 5'd11, 5'd13, 5'd14, 5'd15, 5'd16, 5'd17};

	initial begin
		sys_clk_i = 1'b0;
		forever #2.5 sys_clk_i = ~sys_clk_i;
	end
	trap_vector_dispatch u_trap_vector_dispatch (.sys_clk_i, .sys_rst_i, .placement_i,
		.placement_load_i, .timer_prio_sel_i, .event_i, .instr_i, .instr_valid_i, .instr_ready_o,
		.instr_done_o, .event_taken_o, .vector_o, .pending_o, .placement_o);
	fetch_model u_fetch_model (.sys_clk_i, .go_i(go), .req_i(req), .instr_ready_i(instr_ready_o),
		.instr_o(instr_i), .instr_valid_o(instr_valid_i));

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic report_and_stop();
		$display("checks %0d, mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : report_and_stop
	task automatic tick();
		@(posedge sys_clk_i);
		#1;
	endtask : tick
	function automatic logic [31:0] trap_addr(input logic [5:0] t);
		if (place == 3'h4) return 32'hffff_ff00 + 32'(t) * 4;
		return {place[1:0], 30'h0} + 32'h0000_00fc - 32'(t) * 4;
	endfunction : trap_addr
	function automatic logic [31:0] soft_addr(input logic [3:0] op);
		if (place == 3'h4) return 32'hffff_fe00 + 32'(op) * 16;
		return {place[1:0], 30'h0} + 32'h0000_01fc - 32'(op) * 16;
	endfunction : soft_addr
	task automatic load(input logic [2:0] p, input logic [1:0] s);
		placement_i = p;
		timer_prio_sel_i = s;
		placement_load_i = 1'b1;
		tick();
		placement_load_i = 1'b0;
		place = p;
		tick();
		check(placement_o, p);
	endtask : load
	task automatic wait_ev(input int s, input logic [4:0] p);
		int n;
		n = 0;
		while (event_taken_o !== 1'b1 && n < 20) begin
			tick();
			n++;
		end
		check(event_taken_o, 1'b1);
		check(vector_o.valid, 1'b1);
		check(vector_o.trap_num, trap_of[s]);
		check(vector_o.prio, p);
		check(vector_o.addr, trap_addr(trap_of[s]));
		tick();
	endtask : wait_ev
	task automatic run_ev(input int s, input logic [4:0] p);
		event_i[s] = 1'b1;
		tick();
		event_i = '0;
		wait_ev(s, p);
	endtask : run_ev
	task automatic run_in(input logic [2:0] k, input logic tk, input logic [5:0] t,
		input logic [3:0] op, input logic [3:0] lat, input int n_exp, input logic [31:0] a);
		int n;
		req = '{k, tk, t, op, lat};
		go = 1'b1;
		tick();
		go = 1'b0;
		n = 0;
		while (instr_ready_o !== 1'b1 && n < 20) begin
			tick();
			n++;
		end
		check(instr_ready_o, 1'b1);
		tick();
		check(vector_o.valid, k >= 3'd3 && (tk || k != 3'd3));
		if (k >= 3'd3 && (tk || k != 3'd3)) check(vector_o.addr, a);
		n = 1;
		while (instr_done_o !== 1'b1 && n < 40) begin
			tick();
			n++;
		end
		check(n, n_exp);
	endtask : run_in

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		check(placement_o, 3'h4);
		check(pending_o, '0);
		check(instr_ready_o, 1'b1);
		for (int s = 0; s < 13; s++) if (s != 4) run_ev(s, prio_of[s]);
		$display("reset and event table test done");
	endtask : t_reset
	task automatic t_timer();
		for (int s = 0; s < 4; s++) begin
			load(3'h4, 2'(s));
			run_ev(4, 5'(6 + 2 * s));
		end
		load(3'h4, 2'd1);
		event_i = 13'h0070;
		tick();
		event_i = '0;
		wait_ev(5, 5'd7);
		check(pending_o[6], 1'b1);
		wait_ev(4, 5'd8);
		wait_ev(6, 5'd9);
		$display("timer priority test done");
	endtask : t_timer
	task automatic t_timing();
		run_in(3'd1, 1'b0, 6'd0, 4'h0, 4'h0, 1, 32'h0);
		run_in(3'd2, 1'b0, 6'd0, 4'h0, 4'h0, 1, 32'h0);
		run_in(3'd3, 1'b0, 6'd9, 4'h0, 4'h0, 1, 32'h0);
		run_in(3'd3, 1'b1, 6'd32, 4'h0, 4'h0, 2, trap_addr(6'd32));
		run_in(3'd3, 1'b1, 6'd1, 4'h0, 4'h3, 5, trap_addr(6'd1));
		for (int op = 0; op < 16; op++) run_in(3'd4, 1'b0, 6'd0, 4'(op), 4'h0, 6, soft_addr(4'(op)));
		run_in(3'd4, 1'b0, 6'd0, 4'hf, 4'h4, 6, 32'hffff_fef0);
		run_in(3'd4, 1'b0, 6'd0, 4'he, 4'h7, 9, 32'hffff_fee0);
		run_in(3'd5, 1'b0, 6'd0, 4'h0, 4'h1, 3, 32'hffff_fffc);
		$display("dispatch timing test done");
	endtask : t_timing
	task automatic t_low();
		for (int p = 0; p < 4; p++) begin
			load(3'(p), 2'd0);
			run_ev(0, 5'd2);
			run_ev(12, 5'd17);
			run_in(3'd5, 1'b0, 6'd0, 4'h0, 4'h0, 2, {p[1:0], 30'h0});
			run_in(3'd4, 1'b0, 6'd0, 4'hf, 4'h0, 6, {p[1:0], 30'h0} + 32'h0000_010c);
			run_in(3'd4, 1'b0, 6'd0, 4'he, 4'h0, 6, {p[1:0], 30'h0} + 32'h0000_011c);
			run_in(3'd4, 1'b0, 6'd0, 4'h0, 4'h0, 6, {p[1:0], 30'h0} + 32'h0000_01fc);
		end
		// a placement code above the top one is ignored
		placement_i = 3'h5;
		placement_load_i = 1'b1;
		tick();
		placement_load_i = 1'b0;
		tick();
		check(placement_o, 3'h3);
		$display("low placement test done");
	endtask : t_low

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge sys_clk_i);
		n_errors++;
		report_and_stop();
	end
	initial begin
		n_errors = 0;
		samples_checked = 0;
		sys_rst_i = 1'b1;
		placement_i = 3'h4;
		placement_load_i = 1'b0;
		timer_prio_sel_i = 2'd0;
		event_i = '0;
		go = 1'b0;
		req = '0;
		place = 3'h4;
		repeat (2) @(posedge sys_clk_i);
		#1 sys_rst_i = 1'b0;
		t_reset();
		t_timer();
		t_timing();
		t_low();
		report_and_stop();
	end
endmodule : test_trap_vector_dispatch
